// ---- bor_pkg.sv ----
`default_nettype none
package bor_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned FILTER_TIME_NS = 1000;
  localparam int unsigned FILTER_CYCLES =
    ((FILTER_TIME_NS * (CLK_HZ / 1000000)) + 999) / 1000;
  localparam int unsigned POWER_UP_TIMER_TIME_NS = 64000;
  localparam int unsigned POWER_UP_TIMER_CYCLES =
    ((POWER_UP_TIMER_TIME_NS * (CLK_HZ / 1000000)) + 999) / 1000;

  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_CONFIG = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;

  localparam int unsigned CTRL_SOFT_EN_BIT  = 7;
  localparam int unsigned CTRL_READY_BIT    = 0;
  localparam int unsigned CFG_MODE_LSB      = 0;
  localparam int unsigned CFG_LEVEL_LSB     = 4;
  localparam int unsigned CFG_POWER_UP_TIMER_EN_BIT   = 8;
  localparam int unsigned ST_RESET_BIT      = 0;
  localparam int unsigned ST_BOR_BIT        = 1;
  localparam int unsigned ST_ABORT_BIT      = 2;
  localparam int unsigned ST_MON_EN_BIT     = 3;
  localparam int unsigned ST_WAKE_HOLD_BIT  = 4;

  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_SOFT   = 2'h1;
  localparam logic [1:0] MODE_NOSLP  = 2'h2;
  localparam logic [1:0] MODE_ALWAYS = 2'h3;
  localparam logic [1:0] MODE_RESET  = 2'h3;
  localparam logic [1:0] LEVEL_RESET = 2'h0;
  localparam logic [1:0] LEVEL_ERASE = 2'h0;

  typedef enum logic [1:0] {
    ST_POR  = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN  = 2'b11,
    ST_BOR  = 2'b10
  } bor_state_e;
endpackage
`default_nettype wire

// ---- bor_ctrl.sv ----
// Implementation choices: the APB register port and the register addresses.
`default_nettype none
module bor_ctrl
  import bor_pkg::*;
#(
  parameter int unsigned FILTER_CNT = FILTER_CYCLES,
  parameter int unsigned POWER_UP_TIMER_CNT   = POWER_UP_TIMER_CYCLES,
  parameter logic [1:0]  ERASE_LEVEL = LEVEL_ERASE
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        por_supply_ok,
  input  wire logic        bor_below,
  input  wire logic        bor_ready,
  input  wire logic        ext_reset_n,
  input  wire logic        sleep_req,
  input  wire logic        erase_active,
  output logic             bor_enable,
  output logic      [1:0]  bor_level,
  output logic             core_reset_n,
  output logic             wake_ok,
  output logic             erase_abort
);
  import bor_pkg::*;

  localparam int unsigned CW = 16;

  bor_state_e  state_q;
  logic [1:0]  mode_q;
  logic [1:0]  level_q;
  logic        soft_en_q;
  logic        power_up_timer_en_q;
  logic [CW-1:0] filt_q;
  logic [CW-1:0] power_up_timer_q;
  logic        bor_evt_q;
  logic        abort_sticky_q;
  logic        mon_en;
  logic        protect;
  logic        trip;
  logic        startup_ok;
  logic        wake_hold;
  logic        apb_acc;

  function automatic logic mon_enable(input logic [1:0] m, input logic slp,
                                      input logic sw, input logic er);
    logic en;
    en = 1'b0;
    case (m)
      MODE_ALWAYS: en = 1'b1;
      MODE_NOSLP:  en = !slp;
      MODE_SOFT:   en = sw;
      default:     en = 1'b0;
    endcase
    return en | er;
  endfunction

  always_comb begin
    mon_en     = mon_enable(mode_q, sleep_req, soft_en_q, erase_active);
    protect    = mon_en && bor_ready;
    trip       = protect && (filt_q >= CW'(FILTER_CNT));
    startup_ok = (mode_q == MODE_SOFT) || (mode_q == MODE_OFF) ||
                 (bor_ready && !bor_below);
    wake_hold  = (mode_q == MODE_NOSLP) && !bor_ready;
    apb_acc    = psel && penable;
  end

  // Filter on below-threshold indication
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_q <= '0;
    end else if (clk_en) begin
      if (!(protect && bor_below)) begin
        filt_q <= '0;
      end else if (filt_q < CW'(FILTER_CNT)) begin
        filt_q <= filt_q + 1'b1;
      end
    end
  end

  // Power-up timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_up_timer_q <= '0;
    end else if (clk_en) begin
      if (state_q != ST_WAIT) begin
        power_up_timer_q <= '0;
      end else if (power_up_timer_q < CW'(POWER_UP_TIMER_CNT)) begin
        power_up_timer_q <= power_up_timer_q + 1'b1;
      end
    end
  end

  // Reset sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_POR;
    end else if (clk_en) begin
      case (state_q)
        ST_POR: begin
          if (por_supply_ok) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!por_supply_ok) begin
            state_q <= ST_POR;
          end else if (startup_ok && ext_reset_n &&
                       (!power_up_timer_en_q || power_up_timer_q >= CW'(POWER_UP_TIMER_CNT))) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!por_supply_ok) begin
            state_q <= ST_POR;
          end else if (!ext_reset_n) begin
            state_q <= ST_WAIT;
          end else if (trip && !erase_active) begin
            state_q <= ST_BOR;
          end
        end
        ST_BOR: begin
          if (!por_supply_ok) begin
            state_q <= ST_POR;
          end else if (!bor_below) begin
            state_q <= ST_WAIT;
          end
        end
        default: state_q <= ST_POR;
      endcase
    end
  end

  // Outputs to analog and core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_reset_n <= 1'b0;
      bor_enable   <= 1'b0;
      bor_level    <= LEVEL_RESET;
      wake_ok      <= 1'b0;
      erase_abort  <= 1'b0;
      bor_evt_q    <= 1'b0;
    end else if (clk_en) begin
      core_reset_n <= (state_q == ST_RUN) && !(trip && !erase_active);
      bor_enable   <= mon_en;
      bor_level    <= erase_active ? ERASE_LEVEL : level_q;
      wake_ok      <= !wake_hold;
      erase_abort  <= erase_active && trip;
      if (state_q == ST_BOR) begin
        bor_evt_q <= 1'b1;
      end else if (apb_acc && pwrite && paddr == ADDR_STATUS &&
                   pwdata[ST_BOR_BIT]) begin
        bor_evt_q <= 1'b0;
      end
    end
  end

  // Erase abort sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_sticky_q <= 1'b0;
    end else if (clk_en) begin
      if (erase_active && trip) begin
        abort_sticky_q <= 1'b1;
      end else if (apb_acc && pwrite && paddr == ADDR_STATUS &&
                   pwdata[ST_ABORT_BIT]) begin
        abort_sticky_q <= 1'b0;
      end
    end
  end

  // APB register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q    <= MODE_RESET;
      level_q   <= LEVEL_RESET;
      soft_en_q <= 1'b0;
      power_up_timer_en_q <= 1'b1;
    end else if (clk_en && apb_acc && pwrite) begin
      case (paddr)
        ADDR_CTRL: soft_en_q <= pwdata[CTRL_SOFT_EN_BIT];
        ADDR_CONFIG: begin
          mode_q    <= pwdata[CFG_MODE_LSB +: 2];
          level_q   <= pwdata[CFG_LEVEL_LSB +: 2];
          power_up_timer_en_q <= pwdata[CFG_POWER_UP_TIMER_EN_BIT];
        end
        default: ;
      endcase
    end
  end

  // APB read data and answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        case (paddr)
          ADDR_CTRL: begin
            prdata[CTRL_SOFT_EN_BIT] <= soft_en_q;
            prdata[CTRL_READY_BIT]   <= bor_ready;
          end
          ADDR_CONFIG: begin
            prdata[CFG_MODE_LSB +: 2]  <= mode_q;
            prdata[CFG_LEVEL_LSB +: 2] <= level_q;
            prdata[CFG_POWER_UP_TIMER_EN_BIT]    <= power_up_timer_en_q;
          end
          ADDR_STATUS: begin
            prdata[ST_RESET_BIT]     <= (state_q != ST_RUN);
            prdata[ST_BOR_BIT]       <= bor_evt_q;
            prdata[ST_ABORT_BIT]     <= abort_sticky_q;
            prdata[ST_MON_EN_BIT]    <= mon_en;
            prdata[ST_WAKE_HOLD_BIT] <= wake_hold;
          end
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- bor_monitor.sv ----
`default_nettype none
module bor_monitor #(
  parameter int unsigned FILTER_CNT  = 3,
  parameter logic [1:0]  ERASE_LEVEL = 2'h0
) (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  input wire logic       por_supply_ok,
  input wire logic       bor_below,
  input wire logic       ext_reset_n,
  input wire logic       erase_active,
  input wire logic       bor_enable,
  input wire logic [1:0] bor_level,
  input wire logic       core_reset_n
);
  logic [7:0] low_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_q <= 8'h00;
    else low_q <= bor_below ? low_q + 8'h01 : 8'h00;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence quiet_s;
    (!bor_enable && ext_reset_n && por_supply_ok && !erase_active) [*4];
  endsequence
  sequence erase_s;
    erase_active ##1 erase_active;
  endsequence
  por_gate_a: assert property ($rose(core_reset_n) |-> $past(por_supply_ok))
    else $error("core released without supply");
  ext_gate_a: assert property ($rose(core_reset_n) |-> $past(ext_reset_n))
    else $error("core released with pin low");
  dip_filter_a: assert property ($fell(core_reset_n) && $past(ext_reset_n)
    && $past(por_supply_ok) |-> $past(low_q) >= 8'(FILTER_CNT - 1))
    else $error("reset before filter time");
  monitor_off_a: assert property (quiet_s ##0 core_reset_n |=> core_reset_n)
    else $error("reset with monitor off");
  erase_on_a: assert property (erase_s |-> bor_enable)
    else $error("monitor not forced on");
  erase_level_a: assert property (erase_s |-> bor_level == ERASE_LEVEL)
    else $error("wrong erase level");
  erase_hold_a: assert property (erase_active && core_reset_n && ext_reset_n
    ##1 erase_active |-> core_reset_n)
    else $error("reset during erase");
  bus_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  bus_err_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
bind bor_ctrl bor_monitor #(.FILTER_CNT(FILTER_CNT), .ERASE_LEVEL(ERASE_LEVEL)) mon (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .por_supply_ok, .bor_below,
  .ext_reset_n, .erase_active, .bor_enable, .bor_level, .core_reset_n);
`default_nettype wire

// ---- bor_partner.sv ----
`default_nettype none
module bor_partner #(
  parameter int unsigned RDY_DLY = 4
) (
  input  wire logic pclk,
  input  wire logic bor_enable,
  input  wire logic supply_low,
  output logic      bor_below,
  output logic      bor_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int unsigned cnt;
  always @(posedge pclk) begin
    cnt <= bor_enable ? ((cnt < RDY_DLY) ? cnt + 1 : cnt) : 0;
  end
  assign bor_ready = bor_enable && (cnt >= RDY_DLY);
  assign bor_below = bor_enable ? supply_low : 1'b0;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`default_nettype none
module tb_top;
  import bor_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic        pready, pslverr, e, bor_below, bor_ready, bor_enable;
  logic        por_supply_ok = 1'b0, ext_reset_n = 1'b1, sleep_req = 1'b0;
  logic        erase_active = 1'b0, supply_low = 1'b0, clk_en = 1'b1;
  logic        core_reset_n, wake_ok, erase_abort;
  logic [1:0]  bor_level;
  int          error_cnt = 0, n_compared = 0;
  bor_ctrl #(.FILTER_CNT(3), .POWER_UP_TIMER_CNT(10)) uut (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .por_supply_ok,
    .bor_below, .bor_ready, .ext_reset_n, .sleep_req, .erase_active, .bor_enable,
    .bor_level, .core_reset_n, .wake_ok, .erase_abort);
  bor_partner ana (.pclk, .bor_enable, .supply_low, .bor_below, .bor_ready);
  initial begin
    forever #20 pclk = ~pclk;
  end
  task automatic results;
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      results();
    end
  endtask
  task automatic wait_up;
    int n;
    n = 0;
    while (core_reset_n !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(core_reset_n), 32'h1);
    if (n >= 300) results();
  endtask
  task automatic dip(input int n, input logic exp);
    supply_low <= 1'b1;
    cyc(n);
    chk(32'(core_reset_n), 32'(exp));
    supply_low <= 1'b0;
    cyc(2);
  endtask
  initial begin
    cyc(16);
    presetn <= 1'b1;
    cyc(6);
    chk(32'(core_reset_n), 32'h0);
    por_supply_ok <= 1'b1;
    wait_up();
    clk_en <= 1'b0;
    ext_reset_n <= 1'b0;
    cyc(4);
    chk(32'(core_reset_n), 32'h1);
    ext_reset_n <= 1'b1;
    clk_en <= 1'b1;
    cyc(4);
    chk(32'(core_reset_n), 32'h1);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    chk(r, 32'h103);
    apb(1'b1, ADDR_CTRL, 32'h0);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(r, 32'h1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(32'(e), 32'h1);
    dip(2, 1'b1);
    dip(8, 1'b0);
    wait_up();
    ext_reset_n <= 1'b0;
    cyc(3);
    chk(32'(core_reset_n), 32'h0);
    ext_reset_n <= 1'b1;
    wait_up();
    for (int l = 0; l < 4; l++) begin
      apb(1'b1, ADDR_CONFIG, 32'h103 | 32'(l << 4));
      cyc(3);
      chk(32'(bor_level), 32'(l));
    end
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, ADDR_CONFIG, 32'h100 | 32'(m));
      cyc(3);
      chk(32'(bor_enable), 32'(m >> 1));
      sleep_req <= 1'b1;
      cyc(8);
      chk(32'(bor_enable), 32'(m == 3));
      chk(32'(wake_ok), 32'(m != 2));
      sleep_req <= 1'b0;
      cyc(8);
    end
    apb(1'b1, ADDR_CONFIG, 32'h101);
    apb(1'b1, ADDR_CTRL, 32'h80);
    cyc(3);
    chk(32'(bor_enable), 32'h1);
    sleep_req <= 1'b1;
    cyc(4);
    chk(32'(bor_enable), 32'h1);
    sleep_req <= 1'b0;
    cyc(6);
    dip(8, 1'b0);
    wait_up();
    apb(1'b1, ADDR_CONFIG, 32'h100);
    dip(8, 1'b1);
    erase_active <= 1'b1;
    cyc(8);
    chk(32'(bor_level), 32'(LEVEL_ERASE));
    supply_low <= 1'b1;
    cyc(8);
    chk(32'(erase_abort), 32'h1);
    chk(32'(core_reset_n), 32'h1);
    supply_low <= 1'b0;
    cyc(3);
    chk(32'(erase_abort), 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r, 32'he);
    apb(1'b1, ADDR_STATUS, 32'h6);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(r, 32'h8);
    erase_active <= 1'b0;
    cyc(4);
    results();
  end
endmodule
`default_nettype wire
